/* File: shared/msd_pkg.sv */
// Purpose: shared constants and types for the memory slot decode block
// Assumes: 16 slots of 4K, four blocks, eight banks
// Notes:   bus signals travel as packed structs
package msd_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned OFFS_W     = 12;
  localparam int unsigned SLOT_W     = 4;
  localparam int unsigned NUM_SLOTS  = 16;
  localparam int unsigned NUM_BLOCKS = 4;
  localparam int unsigned BLK_SEL_W  = 2;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned NUM_BANKS  = 8;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] BANK_ENABLE_PORT_ADDR = 8'h40;
  localparam logic [7:0] BANK_MASK_ALL_OFF     = 8'h00;

  // ----------------------------------------------------------------
  // jumper positions
  // ----------------------------------------------------------------
  localparam logic PWRUP_POS1_ENABLED = 1'b0;
  localparam logic WSRC_MWRITE        = 1'b0;
  localparam logic WSRC_PWR           = 1'b1;

  // bus cycle inputs, already synchronised
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              sout;
    logic              smemr;
    logic              pdbin;
    logic              pwr_n;
    logic              mwrite;
    logic              phantom_n;
  } msd_bus_s;

  // board straps, already synchronised
  typedef struct packed {
    logic [NUM_SLOTS/2-1:0] upper_slot_switch;
    logic [NUM_SLOTS/2-1:0] lower_slot_switch;
    logic [NUM_BANKS-1:0]   bank_switch;
    logic                   pwrup_jumper;
    logic                   shadow_jumper;
    logic                   bank_gate_jumper;
    logic                   write_src_jumper;
  } msd_straps_s;

endpackage : msd_pkg

/* File: hw/msd_sync.sv */
// Purpose: two-stage synchroniser for a bundle of pin levels
// Assumes: inputs are asynchronous levels
// Notes:   first stage is read only by the second stage
module msd_sync
  import msd_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // two flops per bit
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule // msd_sync

/* File: hw/msd_top.sv */
// Purpose: slot decode, bank enable and storage for a 16K by 8 memory board
// Assumes: all pins but RESET asynchronous to MCLK, two-flop synchronised
// Notes:   storage is flip-flops; read data registered
module msd_top
  import msd_pkg::*;
#(
  parameter int unsigned BLK_DEPTH = 4096
)
(
  input  wire logic                   MCLK,
  input  wire logic                   RESET,
  input  wire logic [ADDR_W-1:0]      ADDR,
  input  wire logic [DATA_W-1:0]      DATA_OUT_BUS,
  input  wire logic                   SOUT,
  input  wire logic                   SMEMR,
  input  wire logic                   PDBIN,
  input  wire logic                   PWR_N,
  input  wire logic                   MWRITE,
  input  wire logic                   PHANTOM_N,
  input  wire logic [7:0]             UPPER_SLOT_SWITCH,
  input  wire logic [7:0]             LOWER_SLOT_SWITCH,
  input  wire logic [NUM_BANKS-1:0]   BANK_SWITCH,
  input  wire logic                   PWRUP_JUMPER,
  input  wire logic                   SHADOW_JUMPER,
  input  wire logic                   BANK_GATE_JUMPER,
  input  wire logic                   WRITE_SRC_JUMPER,
  output logic      [DATA_W-1:0]      DATA_IN_BUS,
  output logic                        DATA_IN_OE,
  output logic                        ENABLE_LED
);

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  localparam int unsigned BUS_W   = $bits(msd_bus_s);
  localparam int unsigned STRAP_W = $bits(msd_straps_s);

  msd_bus_s    bus_raw;
  msd_bus_s    bus;
  msd_straps_s strap_raw;
  msd_straps_s strap;
  logic [BUS_W-1:0]   bus_sync;
  logic [STRAP_W-1:0] strap_sync;

  // pack pins into bundles
  assign bus_raw = '{addr: ADDR, dout: DATA_OUT_BUS, sout: SOUT, smemr: SMEMR,
                     pdbin: PDBIN, pwr_n: PWR_N, mwrite: MWRITE,
                     phantom_n: PHANTOM_N};
  assign strap_raw = '{upper_slot_switch: UPPER_SLOT_SWITCH,
                       lower_slot_switch: LOWER_SLOT_SWITCH,
                       bank_switch: BANK_SWITCH, pwrup_jumper: PWRUP_JUMPER,
                       shadow_jumper: SHADOW_JUMPER,
                       bank_gate_jumper: BANK_GATE_JUMPER,
                       write_src_jumper: WRITE_SRC_JUMPER};

  msd_sync #(
    .WIDTH (BUS_W)
  ) u_bus_sync (
    .clk  (MCLK),
    .rst  (RESET),
    .din  (bus_raw),
    .dout (bus_sync)
  );

  msd_sync #(
    .WIDTH (STRAP_W)
  ) u_strap_sync (
    .clk  (MCLK),
    .rst  (RESET),
    .din  (strap_raw),
    .dout (strap_sync)
  );

  assign bus   = msd_bus_s'(bus_sync);
  assign strap = msd_straps_s'(strap_sync);

  // ----------------------------------------------------------------
  // strap capture after reset
  // ----------------------------------------------------------------
  logic rst_seen_q;
  logic pwrup_load;

  // first cycle after reset: sync chain still holds reset zeros, not the real jumper level
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      rst_seen_q <= 1'b0;
    else
      rst_seen_q <= 1'b1;
  end

  // two more cycles to flush the synchroniser
  logic [1:0] settle_q;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      settle_q <= 2'b00;
    else if (settle_q != 2'b11)
      settle_q <= settle_q + 2'b01;
  end

  assign pwrup_load = rst_seen_q && (settle_q == 2'b10);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [SLOT_W-1:0]    slot;                 // A15..A12
  logic [OFFS_W-1:0]    offset;               // A11..A0
  logic [NUM_SLOTS-1:0] slot_closed;
  logic [BLK_SEL_W-1:0] blk_idx;
  logic                 slot_hit;
  logic                 phantom_block;
  logic                 mem_cycle_ok;
  logic                 board_enabled;

  assign slot   = bus.addr[ADDR_W-1:OFFS_W];
  assign offset = bus.addr[OFFS_W-1:0];
  // slots 0..7 on the upper switch, 8..F on the lower switch
  assign slot_closed = {strap.lower_slot_switch, strap.upper_slot_switch};
  // a slot feeds only the block congruent to it mod four
  assign blk_idx  = slot[BLK_SEL_W-1:0];
  // any closed slot selects its block, so a block may alias
  assign slot_hit = slot_closed[slot];
  assign phantom_block = strap.shadow_jumper && !bus.phantom_n;
  // output port cycles never reach the storage
  assign mem_cycle_ok  = !bus.sout;

  logic addressed;
  assign addressed = board_enabled && mem_cycle_ok && slot_hit && !phantom_block;

  // one-hot block select, at most one block per access
  logic [NUM_BLOCKS-1:0] blk_sel;
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BLOCKS; gb++)
    begin : g_blk_sel
      assign blk_sel[gb] = addressed && (blk_idx == BLK_SEL_W'(gb));
    end
  endgenerate

  // ----------------------------------------------------------------
  // bank enable port
  // ----------------------------------------------------------------
  logic port_write;
  logic port_strobe;
  logic port_strobe_q;
  logic port_write_edge;
  logic bank_match;
  logic bank_en_q;
  logic bank_en_d;

  // write strobe follows the chosen write source
  assign port_strobe = (strap.write_src_jumper == WSRC_PWR) ? !bus.pwr_n : bus.mwrite;
  assign port_write  = bus.sout && port_strobe &&
                       (bus.addr[7:0] == BANK_ENABLE_PORT_ADDR);
  // latch once per strobe; data held stable by the master
  assign port_write_edge = port_write && !port_strobe_q;
  // any set bit meeting a closed bank switch enables
  assign bank_match = |(bus.dout & strap.bank_switch);

  always_comb
  begin
    bank_en_d = bank_en_q;
    if (pwrup_load)
      bank_en_d = (strap.pwrup_jumper == PWRUP_POS1_ENABLED);
    else if (port_write_edge)
      bank_en_d = bank_match;
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      bank_en_q     <= 1'b0;
      port_strobe_q <= 1'b0;
    end
    else
    begin
      bank_en_q     <= bank_en_d;
      port_strobe_q <= bus.sout && port_strobe;
    end
  end

  // gate removed: port writes have no effect, always on
  assign board_enabled = !strap.bank_gate_jumper || bank_en_q;
  assign ENABLE_LED    = board_enabled;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem_q [NUM_BLOCKS*BLK_DEPTH];
  logic              mem_we;
  logic [BLK_SEL_W+OFFS_W-1:0] mem_idx;

  // write strobe per write-source jumper
  assign mem_we  = (|blk_sel) && port_strobe;
  assign mem_idx = {blk_idx, offset};

  always_ff @(posedge MCLK)
  begin
    if (mem_we)
      mem_q[mem_idx] <= bus.dout;
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic              rd_en;
  logic [DATA_W-1:0] rd_data_q;
  logic              rd_oe_q;

  assign rd_en = addressed && bus.smemr && bus.pdbin;

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      rd_data_q <= 8'h00;
      rd_oe_q   <= 1'b0;
    end
    else
    begin
      rd_oe_q <= rd_en;
      if (rd_en)
        rd_data_q <= mem_q[mem_idx];
    end
  end

  assign DATA_IN_BUS = rd_data_q;
  assign DATA_IN_OE  = rd_oe_q;

endmodule // msd_top

/* File: tb/msd_monitor.sv */
// Purpose: assertion checker for the slot decode block
// Assumes: pins reach the logic through two sync flops
// Notes:   bound to msd_top, sees its ports only
module msd_monitor
  import msd_pkg::*;
(
  input wire logic              MCLK, RESET, SOUT, SMEMR, PDBIN, PWR_N, MWRITE, PHANTOM_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] DATA_OUT_BUS, DATA_IN_BUS,
  input wire logic [7:0]        UPPER_SLOT_SWITCH, LOWER_SLOT_SWITCH, BANK_SWITCH,
  input wire logic              PWRUP_JUMPER, SHADOW_JUMPER, BANK_GATE_JUMPER,
  input wire logic              WRITE_SRC_JUMPER, DATA_IN_OE, ENABLE_LED
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  // ----------------------------------------------------------------
  // helper decode
  // ----------------------------------------------------------------
  wire logic [15:0] slots    = {LOWER_SLOT_SWITCH, UPPER_SLOT_SWITCH};
  wire logic        slot_on  = slots[ADDR[15:12]];
  wire logic        rd_on    = SMEMR && PDBIN;
  wire logic        ph_blk   = SHADOW_JUMPER && !PHANTOM_N;
  wire logic        wr_on    = WRITE_SRC_JUMPER ? !PWR_N : MWRITE;
  wire logic        port_wr  = SOUT && wr_on && (ADDR[7:0] == BANK_ENABLE_PORT_ADDR);
  wire logic        mask_hit = |(DATA_OUT_BUS & BANK_SWITCH);
  wire logic        led_exp  = !PWRUP_JUMPER || !BANK_GATE_JUMPER;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  oe_strobe_a: assert property (DATA_IN_OE |-> $past(rd_on, 3))
    else $error("data driven without both read strobes");
  sout_block_a: assert property (DATA_IN_OE |-> !$past(SOUT, 3))
    else $error("data driven during output port cycle");
  phantom_block_a: assert property (DATA_IN_OE |-> !$past(ph_blk, 3))
    else $error("data driven while phantom blocks access");
  slot_closed_a: assert property (DATA_IN_OE |-> $past(slot_on, 3))
    else $error("data driven for an open slot");
  oe_enabled_a: assert property (DATA_IN_OE |-> ENABLE_LED)
    else $error("data driven while board disabled");
  oe_release_a: assert property ($fell(rd_on) |-> ##3 !DATA_IN_OE)
    else $error("data drive not released after strobes");
  port_enable_a: assert property ($rose(port_wr) && BANK_GATE_JUMPER
    |-> ##4 ENABLE_LED == $past(mask_hit, 4))
    else $error("bank enable latch wrong after port write");
  gate_off_a: assert property (!BANK_GATE_JUMPER [*4] |-> ENABLE_LED)
    else $error("indicator dark with bank gate removed");
  pwrup_state_a: assert property ($fell(RESET) |-> ##5 ENABLE_LED == led_exp)
    else $error("power-up state wrong");
endmodule // msd_monitor

bind msd_top msd_monitor mon_u (.MCLK(MCLK), .RESET(RESET), .SOUT(SOUT), .SMEMR(SMEMR),
  .PDBIN(PDBIN), .PWR_N(PWR_N), .MWRITE(MWRITE), .PHANTOM_N(PHANTOM_N), .ADDR(ADDR),
  .DATA_OUT_BUS(DATA_OUT_BUS), .DATA_IN_BUS(DATA_IN_BUS),
  .UPPER_SLOT_SWITCH(UPPER_SLOT_SWITCH), .LOWER_SLOT_SWITCH(LOWER_SLOT_SWITCH),
  .BANK_SWITCH(BANK_SWITCH), .PWRUP_JUMPER(PWRUP_JUMPER), .SHADOW_JUMPER(SHADOW_JUMPER),
  .BANK_GATE_JUMPER(BANK_GATE_JUMPER), .WRITE_SRC_JUMPER(WRITE_SRC_JUMPER),
  .DATA_IN_OE(DATA_IN_OE), .ENABLE_LED(ENABLE_LED));

/* File: tb/msd_cpu_model.sv */
// Purpose: bus master model for memory and port cycles
// Assumes: write strobe follows the write source jumper
// Notes:   released address and data lines show inverted values, never the last ones; strobes go inactive
module msd_cpu_model
  import msd_pkg::*;
(
  input  wire logic              MCLK,
  input  wire logic              wsrc,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              rd_oe,
  output msd_bus_s               bus
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus from time zero
  initial bus = '{16'h0000, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  // write or port cycle, data held through strobe and three more clocks
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic port);
    @(negedge MCLK);
    bus.addr = a;
    bus.dout = d;
    bus.sout = port;
    bus.pwr_n = !wsrc;
    bus.mwrite = !wsrc;
    repeat (4) @(negedge MCLK);
    bus.pwr_n = 1'b1;
    bus.mwrite = 1'b0;
    repeat (3) @(negedge MCLK);
    bus.sout = 1'b0;
    bus.addr = ~a;
    bus.dout = ~d;
  endtask
  // read cycle, answer taken after the fourth edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic oe);
    @(negedge MCLK);
    bus.addr = a;
    bus.smemr = 1'b1;
    bus.pdbin = 1'b1;
    repeat (4) @(negedge MCLK);
    d = rd_data;
    oe = rd_oe;
    bus.smemr = 1'b0;
    bus.pdbin = 1'b0;
    bus.addr = ~a;
    repeat (4) @(negedge MCLK);
  endtask
endmodule // msd_cpu_model

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the slot decode block
// Assumes: 25 MHz clock, inputs change on the falling edge
// Notes:   shadow memory keyed by block and offset
module testbench
  import msd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        MCLK = 1'b0, RESET = 1'b1, PHANTOM_N = 1'b1, oe, en_q, DATA_IN_OE, ENABLE_LED;
  logic [7:0]  rdat, DATA_IN_BUS;
  logic [31:0] lfsr = 32'h8746_dee5;
  logic [15:0] a;
  msd_straps_s st = '0;
  msd_bus_s    bus;
  int          bad_count = 0, n_checks = 0;
  logic [7:0]  shadow [int];
  initial forever #20 MCLK = ~MCLK;
  msd_cpu_model cpu_u (.MCLK(MCLK), .wsrc(st.write_src_jumper), .rd_data(DATA_IN_BUS),
    .rd_oe(DATA_IN_OE), .bus(bus));
  msd_top dut_u (.MCLK(MCLK), .RESET(RESET), .ADDR(bus.addr), .DATA_OUT_BUS(bus.dout),
    .SOUT(bus.sout), .SMEMR(bus.smemr), .PDBIN(bus.pdbin), .PWR_N(bus.pwr_n),
    .MWRITE(bus.mwrite), .PHANTOM_N(PHANTOM_N), .UPPER_SLOT_SWITCH(st.upper_slot_switch),
    .LOWER_SLOT_SWITCH(st.lower_slot_switch), .BANK_SWITCH(st.bank_switch),
    .PWRUP_JUMPER(st.pwrup_jumper), .SHADOW_JUMPER(st.shadow_jumper),
    .BANK_GATE_JUMPER(st.bank_gate_jumper), .WRITE_SRC_JUMPER(st.write_src_jumper),
    .DATA_IN_BUS(DATA_IN_BUS), .DATA_IN_OE(DATA_IN_OE), .ENABLE_LED(ENABLE_LED));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // access allowed: slot closed, board on, not shadowed
  function automatic logic hit(logic [15:0] ad);
    logic [15:0] sw;
    sw = {st.lower_slot_switch, st.upper_slot_switch};
    return sw[ad[15:12]] && (en_q || !st.bank_gate_jumper) && !(st.shadow_jumper && !PHANTOM_N);
  endfunction
  task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic mem(logic [15:0] ad, logic [7:0] d, logic w);
    int k;
    k = {ad[13:12], ad[11:0]};
    if (w)
    begin
      cpu_u.wr(ad, d, 1'b0);
      if (hit(ad)) shadow[k] = d;
    end
    else
    begin
      cpu_u.rd(ad, rdat, oe);
      cmp("read_oe", hit(ad), oe);
      if (hit(ad) && shadow.exists(k)) cmp("read_data", shadow[k], rdat);
    end
  endtask
  task automatic port(logic [7:0] p, logic [7:0] m);
    cpu_u.wr({8'h00, p}, m, 1'b1);
    if (p == BANK_ENABLE_PORT_ADDR && st.bank_gate_jumper) en_q = |(m & st.bank_switch);
    cmp("led", en_q || !st.bank_gate_jumper, ENABLE_LED);
  endtask
  task automatic do_reset(logic pj);
    @(negedge MCLK);
    RESET = 1'b1;
    st.pwrup_jumper = pj;
    repeat (4) @(negedge MCLK);
    RESET = 1'b0;
    repeat (6) @(negedge MCLK);
    en_q = (pj == PWRUP_POS1_ENABLED);
    cmp("led", en_q || !st.bank_gate_jumper, ENABLE_LED);
  endtask
  // watchdog, about eight times the expected run
  initial
  begin
    #400_000;
    bad_count++;
    print_verdict();
  end
  initial
  begin
    st.bank_gate_jumper = 1'b1;
    st.bank_switch = 8'h04;
    st.upper_slot_switch = 8'h01;
    do_reset(1'b1);
    do_reset(1'b0);
    mem(16'h0040, 8'h5a, 1'b1);
    $display("test reset done");
    for (int n = 0; n < 8; n++) port(8'h40, 8'h01 << n);
    port(8'h40, 8'h00);
    port(8'h40, 8'h0c);
    port(8'h41, 8'h00);
    $display("test bank done");
    for (int i = 0; i < 60; i++)
    begin
      if (i % 15 == 0)
      begin
        st.upper_slot_switch = 8'(rnd());
        st.lower_slot_switch = 8'(rnd());
        // alternate write source so the active-low strobe also stores data
        st.write_src_jumper = i[0];
        port(8'h40, (i == 30) ? 8'h00 : 8'h04);
      end
      a = 16'(rnd());
      mem(a, 8'(rnd()), 1'b1);
      mem(a ^ (16'(rnd()) & 16'hc000), 8'h00, 1'b0);
    end
    $display("test memory done");
    port(8'h40, 8'h04);
    st.upper_slot_switch = 8'hff;
    // all four jumper and phantom combinations, blocking case included
    for (int i = 0; i < 4; i++)
    begin
      st.shadow_jumper = i[0];
      PHANTOM_N = ~i[1];
      mem(16'h0040 ^ (16'(rnd()) & 16'hc000), 8'h00, 1'b0);
    end
    st.bank_gate_jumper = 1'b0;
    port(8'h40, 8'h00);
    mem(16'h0040, 8'h00, 1'b0);
    $display("test options done");
    print_verdict();
  end
endmodule // testbench
